//--- core/umcl_pkg.sv
// Package: register map, field positions and types for the modem control / line status block
package umcl_pkg;

	// Register byte offsets on APB
	localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_LINE_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ENHANCED_FEATURE = 8'h08;
	localparam logic [7:0] ADDR_FLOW_THRESHOLD = 8'h0C;
	localparam logic [7:0] ADDR_FIFO_TRIGGER = 8'h10;
	localparam logic [7:0] ADDR_MODEM_STATE = 8'h14;
	localparam logic [7:0] ADDR_PIN_CONFIG = 8'h18;

	// Modem control field positions
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_THR_EN = 2;
	localparam int MC_RSVD = 3;
	localparam int MC_LOOP = 4;
	localparam int MC_XON_ANY = 5;
	localparam int MC_IR = 6;
	localparam int MC_PRESC = 7;
	// Bits guarded by the enhanced write enable
	localparam logic [7:0] MC_GUARD_MASK = 8'hE4;
	localparam logic [7:0] MC_RSVD_MASK = 8'h08;

	// Enhanced feature write enable position
	localparam int EF_WEN = 4;

	// Pin config bits: DTR pin select, auto RTS enable
	localparam int PC_DTR_SEL = 0;
	localparam int PC_AUTO_RTS = 1;

	// Line status field positions
	localparam int LS_DR = 0;
	localparam int LS_OE = 1;
	localparam int LS_PE = 2;
	localparam int LS_FE = 3;
	localparam int LS_BI = 4;
	localparam int LS_THRE = 5;
	localparam int LS_TEMT = 6;
	localparam int LS_FERR = 7;

	// Modem state positions driven by loopback
	localparam int MS_CTS = 4;
	localparam int MS_DSR = 5;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam int FIFO_DEPTH = 64;
	localparam int PRESC_DIV = 4;

	// Received character with its error flags
	typedef struct packed {
		logic break_flag;
		logic framing_flag;
		logic parity_flag;
		logic [7:0] data;
	} umcl_rx_char_t;

	// Transmitter status from the serializer
	typedef struct packed {
		logic hold_empty;
		logic shift_empty;
	} umcl_tx_stat_t;

endpackage

//--- core/umcl_sync.sv
// Two flip-flop synchroniser for asynchronous pin levels
module umcl_sync import umcl_pkg::*; #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q, meta_d;
	logic [WIDTH-1:0] sync_q, sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule

//--- core/umcl_core.sv
// Modem control and line status block with APB register access
//
// Operation
// - Loopback routes TX to RX and control bits into modem state.
// - Threshold-enable bit gates access to threshold and trigger registers.
// - RTS bit drives active-low RTS; in loopback it drives CTS status.
// - Auto RTS flow control drives RTS instead of the control bit.
// - DTR bit drives DTR pin when selected; pin level writes ignored.
// - Upper three bits and threshold enable writable only with write enable.
// - Control bit enables resume-on-any-character software flow control.
// - FIFO error bit set while any errored character is in receive FIFO.
// - Transmitter empty only when holding and shift registers both empty.
// - Holding-empty bit set when holding register empty; 64 characters allowed.
// - Line low for whole frame stores zero character with break flag.
// - Framing flag reported for head character lacking valid stop bit.
// - Parity flag reported for head character whose parity failed.
// - Overrun bit set when receiver overrun occurred.
// - Data-ready set while receive FIFO holds at least one character.
// - Break, framing, parity status show head character's error flags.
// - Top control bit selects prescaler divide by one or by four.
// - Control bit selects infrared mode or normal serial mode.
// - Outside loopback, CTS status bit is complement of active-low CTS input.
module umcl_core import umcl_pkg::*; #(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Modem pins, active low
	input wire logic cts_n,
	input wire logic dsr_n,
	output logic rts_n,
	output logic dtr_n,
	// Serial line
	input wire logic rx_pin,
	input wire logic tx_serial,
	output logic rx_serial,
	// Receiver character stream
	input wire logic rx_push,
	input wire umcl_rx_char_t rx_char,
	input wire logic rx_pop,
	input wire logic rx_overrun,
	// Transmitter and flow control status
	input wire umcl_tx_stat_t tx_stat,
	input wire logic flow_rts_assert,
	// Mode outputs
	output logic loopback_en,
	output logic xon_any_en,
	output logic infrared_en,
	output logic baud_tick,
	output logic [7:0] flow_threshold,
	output logic [7:0] fifo_trigger
);

	localparam int PW = $clog2(DEPTH);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] pins_s;
	logic rx_s;

	umcl_sync #(.WIDTH(2), .INIT(2'h3)) u_sync_modem (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in({dsr_n, cts_n}),
		.sync_out(pins_s)
	);

	umcl_sync #(.WIDTH(1), .INIT(1'h1)) u_sync_rx (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in(rx_pin),
		.sync_out(rx_s)
	);

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] mc_q, mc_d;
	logic [7:0] ef_q, ef_d;
	logic [7:0] ft_q, ft_d;
	logic [7:0] tr_q, tr_d;
	logic [1:0] pc_q, pc_d;
	logic ovr_q, ovr_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [7:0] ls_w, ms_w;
	logic acc, wr, rd, hit;

	// Error flag FIFO mirroring the receive FIFO
	logic [2:0] ef_mem [DEPTH];
	logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [PW:0] cnt_q, cnt_d;
	logic [PW:0] errcnt_q, errcnt_d;
	logic push_ok, pop_ok, push_err, pop_err;
	logic [2:0] head_err;

	assign acc = psel && penable && !pready_q;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign push_ok = rx_push && (cnt_q != (PW+1)'(DEPTH));
	assign pop_ok = rx_pop && (cnt_q != '0);
	assign head_err = ef_mem[rp_q];
	assign push_err = push_ok && (rx_char.break_flag || rx_char.framing_flag || rx_char.parity_flag);
	assign pop_err = pop_ok && (head_err != 3'h0);

	always_comb begin
		wp_d = push_ok ? wp_q + 1'b1 : wp_q;
		rp_d = pop_ok ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + (PW+1)'(push_ok) - (PW+1)'(pop_ok);
		errcnt_d = errcnt_q + (PW+1)'(push_err) - (PW+1)'(pop_err);
	end

	always_ff @(posedge sys_clk) begin
		if (push_ok)
			ef_mem[wp_q] <= {rx_char.break_flag, rx_char.framing_flag, rx_char.parity_flag};
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			errcnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			errcnt_q <= errcnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status views
	always_comb begin
		ls_w = REG_RESET;
		ls_w[LS_DR] = (cnt_q != '0);
		ls_w[LS_OE] = ovr_q;
		if (cnt_q != '0) begin
			ls_w[LS_BI] = head_err[2];
			ls_w[LS_FE] = head_err[1];
			ls_w[LS_PE] = head_err[0];
		end
		ls_w[LS_THRE] = tx_stat.hold_empty;
		ls_w[LS_TEMT] = tx_stat.hold_empty && tx_stat.shift_empty;
		ls_w[LS_FERR] = (errcnt_q != '0);
		ms_w = REG_RESET;
		if (mc_q[MC_LOOP]) begin
			ms_w[MS_CTS] = mc_q[MC_RTS];
			ms_w[MS_DSR] = mc_q[MC_DTR];
		end else begin
			ms_w[MS_CTS] = !pins_s[0];
			ms_w[MS_DSR] = !pins_s[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB register file
	always_comb begin
		mc_d = mc_q;
		ef_d = ef_q;
		ft_d = ft_q;
		tr_d = tr_q;
		pc_d = pc_q;
		prdata_d = prdata_q;
		pready_d = acc;
		pslverr_d = 1'b0;
		hit = 1'b1;
		// Overrun sticky until line status read; a new overrun wins
		ovr_d = rx_overrun || (ovr_q && !(rd && paddr == ADDR_LINE_STATUS));
		case (paddr)
			ADDR_MODEM_CONTROL: begin
				if (wr) begin
					if (ef_q[EF_WEN])
						mc_d = pwdata[7:0];
					else
						mc_d = (mc_q & MC_GUARD_MASK) | (pwdata[7:0] & ~MC_GUARD_MASK);
					mc_d = mc_d & ~MC_RSVD_MASK;
				end
				prdata_d = {24'h000000, mc_q};
			end
			ADDR_LINE_STATUS: prdata_d = {24'h000000, ls_w};
			ADDR_ENHANCED_FEATURE: begin
				if (wr)
					ef_d = pwdata[7:0];
				prdata_d = {24'h000000, ef_q};
			end
			ADDR_FLOW_THRESHOLD: begin
				if (wr && mc_q[MC_THR_EN] && ef_q[EF_WEN])
					ft_d = pwdata[7:0];
				prdata_d = mc_q[MC_THR_EN] ? {24'h000000, ft_q} : WORD_ZERO;
			end
			ADDR_FIFO_TRIGGER: begin
				if (wr && mc_q[MC_THR_EN] && ef_q[EF_WEN])
					tr_d = pwdata[7:0];
				prdata_d = mc_q[MC_THR_EN] ? {24'h000000, tr_q} : WORD_ZERO;
			end
			ADDR_MODEM_STATE: prdata_d = {24'h000000, ms_w};
			ADDR_PIN_CONFIG: begin
				if (wr)
					pc_d = pwdata[1:0];
				prdata_d = {30'h0, pc_q};
			end
			default: begin
				hit = 1'b0;
				prdata_d = WORD_ZERO;
			end
		endcase
		if (!rd)
			prdata_d = prdata_q;
		if (acc && !hit)
			pslverr_d = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mc_q <= REG_RESET;
			ef_q <= REG_RESET;
			ft_q <= REG_RESET;
			tr_q <= REG_RESET;
			pc_q <= 2'h0;
			ovr_q <= 1'b0;
			prdata_q <= WORD_ZERO;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			mc_q <= mc_d;
			ef_q <= ef_d;
			ft_q <= ft_d;
			tr_q <= tr_d;
			pc_q <= pc_d;
			ovr_q <= ovr_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins, loopback and prescaler
	logic rts_n_q, rts_n_d, dtr_n_q, dtr_n_d, rxs_q, rxs_d, tick_q, tick_d;
	logic [1:0] pre_q, pre_d;

	always_comb begin
		if (mc_q[MC_LOOP])
			rts_n_d = 1'b1;
		else if (pc_q[PC_AUTO_RTS])
			rts_n_d = !flow_rts_assert;
		else
			rts_n_d = !mc_q[MC_RTS];
		// Pin level writes never reach the DTR pin
		dtr_n_d = (pc_q[PC_DTR_SEL] && !mc_q[MC_LOOP]) ? !mc_q[MC_DTR] : 1'b1;
		rxs_d = mc_q[MC_LOOP] ? tx_serial : rx_s;
		pre_d = (pre_q == 2'(PRESC_DIV - 1)) ? 2'h0 : pre_q + 2'h1;
		tick_d = mc_q[MC_PRESC] ? (pre_q == 2'(PRESC_DIV - 1)) : 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rts_n_q <= 1'b1;
			dtr_n_q <= 1'b1;
			rxs_q <= 1'b1;
			pre_q <= 2'h0;
			tick_q <= 1'b0;
		end else begin
			rts_n_q <= rts_n_d;
			dtr_n_q <= dtr_n_d;
			rxs_q <= rxs_d;
			pre_q <= pre_d;
			tick_q <= tick_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign rts_n = rts_n_q;
	assign dtr_n = dtr_n_q;
	assign rx_serial = rxs_q;
	assign baud_tick = tick_q;
	assign loopback_en = mc_q[MC_LOOP];
	assign xon_any_en = mc_q[MC_XON_ANY];
	assign infrared_en = mc_q[MC_IR];
	assign flow_threshold = ft_q;
	assign fifo_trigger = tr_q;

endmodule

//--- sim/umcl_modem.sv
// Peer modem: echoes the handshake lines back after a delay
module umcl_modem #(
	parameter int DLY = 2
) (
	// Clock
	input wire logic sys_clk,
	// Lines from the core
	input wire logic rts_n,
	input wire logic dtr_n,
	// Lines to the core
	output logic cts_n,
	output logic dsr_n,
	output logic rx_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DLY:0] c_q = '1;
	logic [DLY:0] d_q = '1;
	// Serial line echoes the DTR line, so it idles high and the normal receive path is exercised
	assign rx_pin = d_q[DLY];
	always @(posedge sys_clk) begin
		c_q <= {c_q[DLY-1:0], rts_n};
		d_q <= {d_q[DLY-1:0], dtr_n};
	end
	assign cts_n = c_q[DLY];
	assign dsr_n = d_q[DLY];
endmodule

//--- sim/umcl_chk.sv
// Port checks of the modem control and line status core
module umcl_chk import umcl_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// APB
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and modes
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic tx_serial,
	input wire logic rx_serial,
	input wire logic loopback_en,
	input wire logic xon_any_en,
	input wire logic infrared_en
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic rd = pready && !pwrite;
	wire logic ls = rd && paddr == ADDR_LINE_STATUS;
	wire logic mc = rd && paddr == ADDR_MODEM_CONTROL;
	loop_rts_a: assert property (loopback_en |=> rts_n) else $error("rts active in loop");
	loop_dtr_a: assert property (loopback_en |=> dtr_n) else $error("dtr active in loop");
	loop_rx_a: assert property (loopback_en |=> rx_serial == $past(tx_serial))
		else $error("rx not looped");
	tx_empty_a: assert property (ls && prdata[LS_TEMT] |-> prdata[LS_THRE]) else $error("temt without thre");
	fifo_err_a: assert property (ls && |prdata[LS_BI:LS_PE] |-> prdata[LS_FERR]) else $error("ferr low");
	empty_flags_a: assert property (ls && !prdata[LS_DR] |-> !prdata[LS_FERR] && prdata[LS_BI:LS_PE] == 3'h0)
		else $error("flags on empty");
	mc_rsvd_a: assert property (mc |-> !prdata[MC_RSVD] && prdata[31:8] == 24'h0)
		else $error("reserved bit set");
	mode_bits_a: assert property (mc |-> prdata[MC_IR:MC_LOOP] == {infrared_en, xon_any_en, loopback_en})
		else $error("mode mismatch");
	ls_write_a: assert property (pready && pwrite && paddr == ADDR_LINE_STATUS |-> !pslverr)
		else $error("ls write error");
	cover property (loopback_en ##1 !loopback_en);
	cover property (ls && prdata[LS_FERR]);
	cover property (pslverr);
endmodule
bind umcl_core umcl_chk u_chk (.sys_clk, .rst_n, .pwrite, .paddr, .prdata, .pready, .pslverr, .rts_n, .dtr_n,
	.tx_serial, .rx_serial, .loopback_en, .xon_any_en, .infrared_en);

//--- sim/uart_modem_ctrl_line_status_test.sv
// Self-checking bench of the modem control and line status core
module uart_modem_ctrl_line_status_test import umcl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, tx_serial = 1;
	logic rx_push = 0, rx_pop = 0, rx_overrun = 0, flow_rts_assert = 0, ovr = 0, se;
	logic [7:0] paddr = 0, flow_threshold, fifo_trigger, v;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, cts_n, dsr_n, rts_n, dtr_n, rx_pin, rx_serial;
	logic loopback_en, xon_any_en, infrared_en, baud_tick;
	umcl_rx_char_t rx_char = '0;
	umcl_tx_stat_t tx_stat = 2'h3;
	logic [10:0] q[$];
	int err_count = 0, checks = 0, cyc = 0, n;
	umcl_core #(.DEPTH(FIFO_DEPTH)) DUT (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cts_n, .dsr_n, .rts_n, .dtr_n, .rx_pin, .tx_serial, .rx_serial, .rx_push, .rx_char,
		.rx_pop, .rx_overrun, .tx_stat, .flow_rts_assert, .loopback_en, .xon_any_en, .infrared_en, .baud_tick,
		.flow_threshold, .fifo_trigger);
	umcl_modem #(.DLY(2)) peer (.sys_clk, .rts_n, .dtr_n, .cts_n, .dsr_n, .rx_pin);
	initial forever #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			complete_run();
		end
	end
	////////////////////////////////////////
	task automatic complete_run();
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Model of line status from the queued characters
	task automatic rl();
		logic [2:0] f, h;
		logic [31:0] e;
		f = 0;
		h = 0;
		foreach (q[i]) f |= q[i][10:8];
		if (q.size() != 0) h = q[0][10:8];
		apb(0, ADDR_LINE_STATUS, 0);
		e = {24'h0, |f, &tx_stat, tx_stat.hold_empty, h, ovr, q.size() != 0};
		cmp(rd, e);
		ovr = 0;
	endtask
	task automatic pulse(input int k, input logic [10:0] c);
		@(posedge sys_clk);
		rx_push <= k == 0;
		rx_pop <= k == 1;
		rx_overrun <= k == 2;
		rx_char <= c;
		@(posedge sys_clk);
		{rx_push, rx_pop, rx_overrun} <= 3'h0;
		if (k == 0) q.push_back(c);
		if (k == 1) void'(q.pop_front());
		if (k == 2) ovr = 1;
	endtask
	task automatic ticks(input int e);
		n = 0;
		repeat (8) begin
			@(posedge sys_clk);
			n += 32'(baud_tick);
		end
		cmp(n, e);
	endtask
	////////////////////////////////////////
	initial begin
		n = $urandom(61);
		repeat (3) @(posedge sys_clk);
		rst_n <= 1;
		rl();
		apb(1, ADDR_MODEM_CONTROL, 32'hFF);
		apb(0, ADDR_MODEM_CONTROL, 0);
		cmp(rd, 32'h13);
		apb(1, ADDR_ENHANCED_FEATURE, 32'h10);
		apb(1, ADDR_MODEM_CONTROL, 32'hFF);
		apb(0, ADDR_MODEM_CONTROL, 0);
		cmp(rd, 32'hF7);
		cmp(32'({xon_any_en, infrared_en, loopback_en, rts_n, dtr_n}), 32'h1F);
		apb(0, ADDR_MODEM_STATE, 0);
		cmp(rd, 32'h30);
		repeat (4) begin
			tx_serial <= 1'($urandom);
			repeat (2) @(posedge sys_clk);
			cmp(32'(rx_serial), 32'(tx_serial));
		end
		ticks(2);
		for (int i = 0; i < 2; i++) begin
			v = 8'($urandom);
			apb(1, ADDR_FLOW_THRESHOLD + 8'(4 * i), 32'(v));
			apb(0, ADDR_FLOW_THRESHOLD + 8'(4 * i), 0);
			cmp(rd, 32'(v));
			cmp(32'(i != 0 ? fifo_trigger : flow_threshold), 32'(v));
		end
		apb(1, ADDR_MODEM_CONTROL, 32'h03);
		apb(1, ADDR_FLOW_THRESHOLD, 32'h5A);
		apb(1, ADDR_FIFO_TRIGGER, 32'hA5);
		cmp(32'(fifo_trigger), 32'(v));
		apb(0, ADDR_FLOW_THRESHOLD, 0);
		cmp(rd, 0);
		ticks(8);
		apb(1, ADDR_PIN_CONFIG, 1);
		for (int i = 0; i < 4; i++) begin
			apb(1, ADDR_MODEM_CONTROL, 32'(i));
			repeat (8) @(posedge sys_clk);
			cmp(32'({rts_n, dtr_n}), 32'(3 - i));
			cmp(32'(rx_serial), 32'(!i[0]));
			apb(0, ADDR_MODEM_STATE, 0);
			cmp(rd, 32'({i[0], i[1], 4'h0}));
		end
		apb(1, ADDR_PIN_CONFIG, 3);
		for (int i = 0; i < 2; i++) begin
			flow_rts_assert <= 1'(i);
			repeat (3) @(posedge sys_clk);
			cmp(32'(rts_n), 32'(1 - i));
		end
		repeat (6) pulse(0, 11'($urandom));
		pulse(2, 0);
		apb(1, ADDR_LINE_STATUS, 32'hFF);
		cmp(32'(se), 0);
		while (q.size() != 0) begin
			rl();
			pulse(1, 0);
		end
		for (int i = 0; i < 4; i++) begin
			tx_stat <= 2'(i);
			rl();
		end
		apb(0, 8'h1C, 0);
		cmp(rd, 32'h0);
		cmp(32'(se), 1);
		complete_run();
	end
endmodule
